/* common/scc_consts.svh */
// Purpose: constants for the stop-release and subclock clock controller
// Assumes: register port offsets are word indices on a plain port
// Notes:   offsets, fields, two resets and the reset stabilisation count live here
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH

// ****************************************
// register map (word index = byte address)
// ****************************************
`define SCC_ADDR_W          4
`define SCC_OFS_CLK_CTRL    4'h0
`define SCC_OFS_STAB_SEL    4'h1
`define SCC_OFS_PSAVE       4'h2
`define SCC_OFS_PERIPH_SEL  4'h3
`define SCC_OFS_STATUS      4'h4
`define SCC_OFS_RT_BUF      4'h5
`define SCC_OFS_CONV        4'h6

// ****************************************
// fields and reset values
// ****************************************
`define SCC_CTRL_DIV_LO     0
`define SCC_CTRL_DIV_HI     2
`define SCC_CTRL_SUB_SEL    3
`define SCC_CTRL_OSC_STOP   4
`define SCC_CTRL_STOP_REQ   5
`define SCC_STAB_RESET      3'h4
`define SCC_PSAVE_RESET     3'h0
`define SCC_STAB_W          3
`define SCC_STAB_LOG2_RST   15
`define SCC_STAB_CNT_W      16

`endif

/* common/scc_pkg.sv */
// Purpose: types shared by the clock controller
// Assumes: scc_consts.svh holds the numbers
// Notes:   none
package scc_pkg;

  typedef enum logic [1:0] {
    SCC_RUN,
    SCC_STOPPED,
    SCC_STABILISE
  } scc_state_t;

  typedef struct packed {
    logic       sub_sel;
    logic       osc_stop;
    logic [2:0] divider;
  } scc_clk_ctrl_t;

  typedef struct packed {
    logic csi_ext_clk;
    logic uart_a_ext_clk;
    logic rt_trig_timer;
    logic timer_in_stop;
  } scc_periph_sel_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic csi_clk_en;
    logic uart_a_clk_en;
    logic uart_b_clk_en;
    logic twi_clk_en;
    logic conv_clk_en;
    logic rt_fire_en;
    logic rt_buf_wr_en;
    logic port_hold;
  } scc_gates_t;

endpackage : scc_pkg

/* rtl/scc_ctrl.sv */
// Purpose: stop-release timing and subclock operation mode control
// Assumes: main and subclock are sampled levels; gating is by enables
// Notes:   one clock domain; clock source choice is an enable per edge
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "scc_consts.svh"

module scc_ctrl #(
  parameter int STAB_LOG2_RST = `SCC_STAB_LOG2_RST
) (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_n,
  input  wire logic [`SCC_ADDR_W-1:0] i_addr,
  input  wire logic [7:0]             i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic [7:0]                  o_rdata,
  input  wire logic                   i_main_osc_tick,
  input  wire logic                   i_sub_osc_tick,
  input  wire logic                   i_nmi_req,
  input  wire logic [1:0]             i_ext_nmi_req,
  input  wire logic                   i_mask_req,
  input  wire logic                   i_watchdog_one_reset,
  input  wire logic                   i_watchdog_two_reset,
  output logic                        o_main_osc_en,
  output logic                        o_sysclk_en,
  output logic                        o_sub_active,
  output scc_pkg::scc_gates_t         o_gates
);
  import scc_pkg::*;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic [5:0] sync_in;
  assign sync_in = {i_main_osc_tick, i_sub_osc_tick, i_nmi_req,
                    i_ext_nmi_req, i_mask_req};

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end else begin
      sync1_r <= sync_in;
      sync2_r <= sync1_r;
    end
  end

  logic main_tick;
  logic sub_tick;
  logic nmi_s;
  logic [1:0] ext_nmi_s;
  logic mask_s;
  assign main_tick = sync2_r[5];
  assign sub_tick  = sync2_r[4];
  assign nmi_s     = sync2_r[3];
  assign ext_nmi_s = sync2_r[2:1];
  assign mask_s    = sync2_r[0];

  // watchdog resets come from core-clock logic; treat as ordinary reset
  logic wdt_rst;
  assign wdt_rst = i_watchdog_one_reset | i_watchdog_two_reset;

  // ****************************************
  // registers
  // ****************************************
  scc_clk_ctrl_t            ctrl_r;
  logic [`SCC_STAB_W-1:0]   stab_sel_r;
  logic [2:0]               psave_r;
  scc_periph_sel_t          periph_r;
  logic [7:0]               rt_buf_r;
  logic [1:0]               conv_r;
  scc_state_t               state_r;
  logic                     from_reset_r;
  logic                     stop_wr;

  assign stop_wr = i_wr && (i_addr == `SCC_OFS_CLK_CTRL) &&
                   i_wdata[`SCC_CTRL_STOP_REQ];

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_r <= '0;
    end else if (wdt_rst) begin
      ctrl_r <= '0;
    end else if (i_wr && i_addr == `SCC_OFS_CLK_CTRL &&
                 state_r == SCC_RUN) begin
      ctrl_r.divider  <= i_wdata[`SCC_CTRL_DIV_HI:`SCC_CTRL_DIV_LO];
      ctrl_r.sub_sel  <= i_wdata[`SCC_CTRL_SUB_SEL];
      ctrl_r.osc_stop <= i_wdata[`SCC_CTRL_OSC_STOP];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stab_sel_r <= `SCC_STAB_RESET;
      psave_r    <= `SCC_PSAVE_RESET;
      periph_r   <= '0;
      conv_r     <= 2'h0;
    end else if (wdt_rst) begin
      stab_sel_r <= `SCC_STAB_RESET;
      psave_r    <= `SCC_PSAVE_RESET;
      periph_r   <= '0;
      conv_r     <= 2'h0;
    end else if (i_wr && state_r == SCC_RUN) begin
      // register writes ignored while stopped: state is retained
      case (i_addr)
        `SCC_OFS_STAB_SEL:   stab_sel_r <= i_wdata[`SCC_STAB_W-1:0];
        `SCC_OFS_PSAVE:      psave_r    <= i_wdata[2:0];
        `SCC_OFS_PERIPH_SEL: periph_r   <= i_wdata[3:0];
        `SCC_OFS_CONV:       conv_r     <= i_wdata[1:0];
        default: ;
      endcase
    end
  end

  // real-time output buffer: only the processor writes it
  // the registered gate lags by a cycle, so the state itself decides
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rt_buf_r <= 8'h00;
    end else if (i_wr && i_addr == `SCC_OFS_RT_BUF &&
                 state_r == SCC_RUN) begin
      rt_buf_r <= i_wdata;
    end
  end

  // ****************************************
  // stop / stabilisation sequencer
  // ****************************************
  logic wake;
  // masked sources never release stop
  assign wake = (nmi_s) || (ext_nmi_s[0] && !psave_r[0]) ||
                (ext_nmi_s[1] && !psave_r[1]) || (mask_s && !psave_r[2]);

  logic [`SCC_STAB_CNT_W-1:0] stab_cnt_r;
  logic [`SCC_STAB_CNT_W-1:0] stab_target;
  logic [4:0]                 stab_log2;

  // interrupt release uses programmed interval, reset the default
  always_comb begin
    case (stab_sel_r)
      3'h0:    stab_log2 = 5'h0D;
      3'h1:    stab_log2 = 5'h0E;
      3'h2:    stab_log2 = 5'h0F;
      3'h3:    stab_log2 = 5'h10;
      3'h4:    stab_log2 = 5'(STAB_LOG2_RST);
      default: stab_log2 = 5'(STAB_LOG2_RST);
    endcase
    if (from_reset_r)
      stab_log2 = 5'(STAB_LOG2_RST);
    stab_target = `SCC_STAB_CNT_W'((17'h1 << stab_log2) - 17'h1);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r      <= SCC_STABILISE; // reset release waits too
      from_reset_r <= 1'b1;
      stab_cnt_r   <= '0;
    end else if (wdt_rst) begin
      state_r      <= SCC_STABILISE;
      from_reset_r <= 1'b1;
      stab_cnt_r   <= '0;
    end else begin
      case (state_r)
        SCC_RUN: begin
          if (stop_wr) begin
            state_r <= SCC_STOPPED;
          end
        end
        SCC_STOPPED: begin
          if (wake) begin
            state_r      <= SCC_STABILISE;
            from_reset_r <= 1'b0;
            stab_cnt_r   <= '0;
          end
        end
        SCC_STABILISE: begin
          // counts restarted main oscillator ticks
          if (main_tick) begin
            if (stab_cnt_r == stab_target) begin
              state_r <= SCC_RUN;
            end else begin
              stab_cnt_r <= stab_cnt_r + 1'b1;
            end
          end
        end
        default: state_r <= SCC_RUN;
      endcase
    end
  end

  // ****************************************
  // clock source and gating
  // ****************************************
  logic running;
  logic stopped;
  assign running = (state_r == SCC_RUN);
  assign stopped = (state_r == SCC_STOPPED);

  // source change takes effect only at a tick boundary, so no runt pulse
  logic sub_src_r;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sub_src_r <= 1'b0;
    end else if (wdt_rst) begin
      // safe without a boundary: clocks stay gated while restabilising
      sub_src_r <= 1'b0;
    end else if (sub_src_r ? sub_tick : main_tick) begin
      sub_src_r <= ctrl_r.sub_sel;
    end
  end

  logic sys_tick;
  assign sys_tick = sub_src_r ? sub_tick : main_tick;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sysclk_en   <= 1'b0;
      o_main_osc_en <= 1'b1;
      o_sub_active  <= 1'b0;
    end else begin
      o_sysclk_en   <= running && sys_tick;
      // oscillator off while stopped, or by software in subclock mode
      o_main_osc_en <= !stopped && !(ctrl_r.osc_stop && sub_src_r);
      o_sub_active  <= sub_src_r;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_gates <= '0;
    end else begin
      o_gates.cpu_clk_en    <= running;
      o_gates.csi_clk_en    <= running || periph_r.csi_ext_clk;
      o_gates.uart_a_clk_en <= running || periph_r.uart_a_ext_clk;
      o_gates.uart_b_clk_en <= running;
      o_gates.twi_clk_en    <= running;
      o_gates.conv_clk_en   <= running && conv_r != 2'h0;
      o_gates.rt_fire_en    <= running ||
                               (periph_r.rt_trig_timer &&
                                periph_r.timer_in_stop);
      o_gates.rt_buf_wr_en  <= running;
      o_gates.port_hold     <= !running;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `SCC_OFS_CLK_CTRL:   o_rdata <= {3'h0, ctrl_r.osc_stop,
                                         ctrl_r.sub_sel, ctrl_r.divider};
        `SCC_OFS_STAB_SEL:   o_rdata <= {5'h00, stab_sel_r};
        `SCC_OFS_PSAVE:      o_rdata <= {5'h00, psave_r};
        `SCC_OFS_PERIPH_SEL: o_rdata <= {4'h0, periph_r};
        `SCC_OFS_STATUS:     o_rdata <= {4'h0, from_reset_r, sub_src_r,
                                         state_r};
        `SCC_OFS_RT_BUF:     o_rdata <= rt_buf_r;
        `SCC_OFS_CONV:       o_rdata <= {6'h00, conv_r};
        default:             o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_stop_gates;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    stopped |=> !o_gates.cpu_clk_en && !o_gates.twi_clk_en;
  endproperty
  a_stop_gates: assert property (p_stop_gates)
    else $error("clocks not gated in stop");

  property p_masked_no_wake;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    stopped && !wake && !wdt_rst |=> stopped;
  endproperty
  a_masked_no_wake: assert property (p_masked_no_wake)
    else $error("stop left without request");

  property p_wake_stab;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    stopped && wake && !wdt_rst |=> state_r == SCC_STABILISE;
  endproperty
  a_wake_stab: assert property (p_wake_stab)
    else $error("release skipped stabilisation");

  property p_reset_default;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    wdt_rst |=> from_reset_r && state_r == SCC_STABILISE;
  endproperty
  a_reset_default: assert property (p_reset_default)
    else $error("reset release not like reset");

  property p_no_clk_in_stab;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    state_r == SCC_STABILISE |=> !o_sysclk_en;
  endproperty
  a_no_clk_in_stab: assert property (p_no_clk_in_stab)
    else $error("clock supplied during stabilisation");

  property p_port_hold;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    stopped |=> o_gates.port_hold;
  endproperty
  a_port_hold: assert property (p_port_hold)
    else $error("ports not held in stop");

  property p_rt_buf;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !running |=> $stable(rt_buf_r);
  endproperty
  a_rt_buf: assert property (p_rt_buf)
    else $error("rt buffer changed while stopped");

  property p_src_on_tick;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    $changed(sub_src_r) |-> $past(sys_tick) || $past(wdt_rst);
  endproperty
  a_src_on_tick: assert property (p_src_on_tick)
    else $error("source switched off boundary");

  property p_wdt_sub_exit;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    wdt_rst |-> ##2 !o_sub_active;
  endproperty
  a_wdt_sub_exit: assert property (p_wdt_sub_exit)
    else $error("subclock kept after watchdog reset");

  property p_osc_stop_halts;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    ctrl_r.osc_stop && sub_src_r |=> !o_main_osc_en;
  endproperty
  a_osc_stop_halts: assert property (p_osc_stop_halts)
    else $error("main oscillator left running");

  property p_uart_b_stop;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    stopped |=> !o_gates.uart_b_clk_en && !o_gates.conv_clk_en;
  endproperty
  a_uart_b_stop: assert property (p_uart_b_stop)
    else $error("channel clock running in stop");

endmodule : scc_ctrl

/* verif/stop_release_and_subclock_mode_tb_top.sv */
// Purpose: self-checking bench for the stop-release and subclock controller
// Assumes: main tick every 4 cycles while enabled, subclock tick every 16
// Notes:   read results go through a queue; timing checks use windows
`timescale 1ns/1ps
`include "scc_consts.svh"

module stop_release_and_subclock_mode_tb_top;
  import scc_pkg::*;

  // ****************************************
  // signals
  // ****************************************
  localparam int LOG2_RST = 3;
  localparam int WAKE_N   = 4 * 8192;
  logic            i_core_clk           = 1'b0;
  logic            i_rst_n              = 1'b0;
  logic [3:0]      i_addr               = 4'h0;
  logic [7:0]      i_wdata              = 8'h00;
  logic            i_wr                 = 1'b0;
  logic            i_rd                 = 1'b0;
  logic            i_main_osc_tick      = 1'b0;
  logic            i_sub_osc_tick       = 1'b0;
  logic            i_nmi_req            = 1'b0;
  logic [1:0]      i_ext_nmi_req        = 2'h0;
  logic            i_mask_req           = 1'b0;
  logic [1:0]      wd_rst               = 2'h0;
  logic [7:0]      o_rdata;
  logic            o_main_osc_en;
  logic            o_sysclk_en;
  logic            o_sub_active;
  scc_gates_t      o_gates;
  logic [3:0]      tcnt                 = 4'h0;
  logic            rd_q                 = 1'b0;
  logic [7:0]      exp_q[$];
  logic [7:0]      msk_q[$];
  logic [31:0]     seed                 = 32'h61A3E7E2;
  int              fail_count           = 0;
  int              num_checks           = 0;

  scc_ctrl #(.STAB_LOG2_RST(LOG2_RST)) dut (
    .i_core_clk          (i_core_clk),
    .i_rst_n             (i_rst_n),
    .i_addr              (i_addr),
    .i_wdata             (i_wdata),
    .i_wr                (i_wr),
    .i_rd                (i_rd),
    .o_rdata             (o_rdata),
    .i_main_osc_tick     (i_main_osc_tick),
    .i_sub_osc_tick      (i_sub_osc_tick),
    .i_nmi_req           (i_nmi_req),
    .i_ext_nmi_req       (i_ext_nmi_req),
    .i_mask_req          (i_mask_req),
    .i_watchdog_one_reset(wd_rst[0]),
    .i_watchdog_two_reset(wd_rst[1]),
    .o_main_osc_en       (o_main_osc_en),
    .o_sysclk_en         (o_sysclk_en),
    .o_sub_active        (o_sub_active),
    .o_gates             (o_gates)
  );

  // ****************************************
  // clock, oscillator ticks, read monitor
  // ****************************************
  initial begin
    forever #10 i_core_clk = ~i_core_clk;
  end

  // a stopped oscillator gives no ticks, so a wait cannot finish early
  always @(posedge i_core_clk) begin
    tcnt            <= tcnt + 4'h1;
    i_main_osc_tick <= (tcnt[1:0] == 2'h0) && (o_main_osc_en === 1'b1);
    i_sub_osc_tick  <= (tcnt == 4'h0);
    rd_q            <= i_rd;
  end

  always @(negedge i_core_clk) begin : rd_mon
    logic [7:0] e;
    logic [7:0] m;
    if (rd_q === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp("read queue", 16'h1, 16'h0);
      end else begin
        e = exp_q.pop_front();
        m = msk_q.pop_front();
        cmp("rdata", 16'(e & m), 16'(o_rdata & m));
      end
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic cmp(input string w, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", w, e, g);
    end
  endtask : cmp

  task automatic rng(input string w, input int lo, input int hi, input int n);
    num_checks++;
    if (n < lo || n > hi) begin
      fail_count++;
      $display("unexpected %s expected %0d..%0d seen %0d", w, lo, hi, n);
    end
  endtask : rng

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge i_core_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
  endtask : rd

  task automatic wait_run(input int lo, input int hi);
    int n;
    n = 0;
    while (o_gates.cpu_clk_en !== 1'b1 && n < hi + 10) begin
      @(negedge i_core_clk);
      n++;
    end
    rng("wake cycles", lo, hi, n);
  endtask : wait_run

  task automatic pulses(input int lo, input int hi);
    int n;
    n = 0;
    repeat (320) begin
      @(negedge i_core_clk);
      if (o_sysclk_en === 1'b1) n++;
    end
    rng("sysclk pulses", lo, hi, n);
  endtask : pulses

  task automatic stop_chk(input logic [3:0] ps);
    scc_gates_t e;
    e               = '0;
    // the select struct packs the serial clock choice in its top bit
    e.csi_clk_en    = ps[3];
    e.uart_a_clk_en = ps[2];
    e.rt_fire_en    = ps[1] & ps[0];
    e.port_hold     = 1'b1;
    wr(`SCC_OFS_PERIPH_SEL, {4'h0, ps});
    wr(`SCC_OFS_CLK_CTRL, 8'h22);
    repeat (3) @(negedge i_core_clk);
    cmp("stop gates", 16'(e), 16'(o_gates));
    cmp("osc en in stop", 16'h0, 16'(o_main_osc_en));
    rd(`SCC_OFS_STATUS, {6'h00, SCC_STOPPED}, 8'h07);
  endtask : stop_chk

  task automatic summarize();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    logic [7:0] d;
    logic [3:0] ps;
    repeat (6) @(posedge i_core_clk);
    @(negedge i_core_clk);
    cmp("reset outputs", 16'h8000, {o_main_osc_en, o_sub_active, 5'h0,
        o_gates[8:0]});
    @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    wait_run(4 * 8 - 8, 4 * 8 + 40);
    rd(`SCC_OFS_STAB_SEL, 8'h04, 8'h07);
    rd(`SCC_OFS_PSAVE, 8'h00, 8'h07);
    rd(4'hF, 8'h00, 8'hFF);
    wr(`SCC_OFS_CONV, 8'h03);
    repeat (2) @(negedge i_core_clk);
    cmp("run gates", 16'h01FE, 16'(o_gates));
    wr(`SCC_OFS_CONV, 8'h00);
    seed = xs(seed);
    d    = seed[7:0];
    wr(`SCC_OFS_RT_BUF, d);
    rd(`SCC_OFS_RT_BUF, d, 8'hFF);
    wr(`SCC_OFS_STAB_SEL, 8'h00);
    // masked requests must leave the block stopped
    wr(`SCC_OFS_PSAVE, 8'h07);
    seed = xs(seed);
    ps   = seed[3:0];
    stop_chk(ps);
    wr(`SCC_OFS_RT_BUF, ~d);
    @(posedge i_core_clk);
    i_mask_req    <= 1'b1;
    i_ext_nmi_req <= 2'h3;
    repeat (60) @(negedge i_core_clk);
    cmp("masked wake", 16'h0, 16'(o_gates.cpu_clk_en));
    @(posedge i_core_clk);
    i_mask_req    <= 1'b0;
    i_ext_nmi_req <= 2'h0;
    i_nmi_req     <= 1'b1;
    wait_run(WAKE_N - 8, WAKE_N + 60);
    @(posedge i_core_clk);
    i_nmi_req <= 1'b0;
    rd(`SCC_OFS_RT_BUF, d, 8'hFF);
    rd(`SCC_OFS_PERIPH_SEL, {4'h0, ps}, 8'h0F);
    @(negedge i_core_clk);
    cmp("port hold after wake", 16'h0, 16'(o_gates.port_hold));
    // an unmasked maskable request wakes the block
    wr(`SCC_OFS_PSAVE, 8'h00);
    seed = xs(seed);
    stop_chk(seed[3:0]);
    @(posedge i_core_clk);
    i_mask_req <= 1'b1;
    wait_run(WAKE_N - 8, WAKE_N + 60);
    @(posedge i_core_clk);
    i_mask_req <= 1'b0;
    // subclock mode in and out, divider kept at 2
    wr(`SCC_OFS_CLK_CTRL, 8'h0A);
    repeat (40) @(negedge i_core_clk);
    cmp("sub active", 16'h1, 16'(o_sub_active));
    rd(`SCC_OFS_CLK_CTRL, 8'h0A, 8'h1F);
    pulses(18, 22);
    wr(`SCC_OFS_CLK_CTRL, 8'h1A);
    repeat (4) @(negedge i_core_clk);
    cmp("main osc en", 16'h0, 16'(o_main_osc_en));
    pulses(18, 22);
    wr(`SCC_OFS_CLK_CTRL, 8'h0A);
    repeat (200) @(posedge i_core_clk);
    wr(`SCC_OFS_CLK_CTRL, 8'h02);
    repeat (40) @(negedge i_core_clk);
    cmp("sub after clear", 16'h0, 16'(o_sub_active));
    pulses(78, 82);
    // either watchdog reset leaves subclock mode and restabilises
    for (int k = 0; k < 2; k++) begin
      wr(`SCC_OFS_CLK_CTRL, 8'h0A);
      repeat (40) @(posedge i_core_clk);
      wd_rst <= (k == 0) ? 2'h1 : 2'h2;
      @(posedge i_core_clk);
      wd_rst <= 2'h0;
      repeat (2) @(negedge i_core_clk);
      cmp("sub after wdt", 16'h0, 16'(o_sub_active));
      wait_run(4 * 8 - 12, 4 * 8 + 40);
      rd(`SCC_OFS_CLK_CTRL, 8'h00, 8'h18);
    end
    repeat (4) @(posedge i_core_clk);
    summarize();
  end

  // two long wakes dominate; the limit leaves room for the rest
  initial begin
    repeat (90000) @(posedge i_core_clk);
    fail_count++;
    summarize();
  end

endmodule : stop_release_and_subclock_mode_tb_top
